// ===== include/tbb_pkg.sv
package tbb_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned TBB_WORD_W  = 36;
	localparam int unsigned TBB_CNT_W   = 7;
	localparam int unsigned TBB_ADDR_W  = 7;
	localparam int unsigned TBB_DEPTH   = 120;
	localparam int unsigned TBB_FIFO_D  = 4;

	// ==========================================================
	// Counter figures
	localparam logic [6:0] TBB_CNT_FULL = 7'h78;  // 120 words
	localparam logic [6:0] TBB_CNT_MAX  = 7'h7f;  // 127 saturation
	localparam logic [6:0] TBB_CNT_ZERO = 7'h00;
	localparam logic [9:0] TBB_LINES_PER_BLOCK = 10'h2d0; // 720 lines

	// ==========================================================
	// Function operand field positions (36-bit operand)
	localparam int unsigned TBB_F_BUF1   = 0;  // Buffer / control unit 1
	localparam int unsigned TBB_F_BUF2   = 1;  // Buffer / control unit 2
	localparam int unsigned TBB_F_WRBUF  = 2;  // Write buffer
	localparam int unsigned TBB_F_RDBUF  = 3;  // Read buffer
	localparam int unsigned TBB_F_ENDX   = 4;  // End transfer
	localparam int unsigned TBB_F_CLR    = 5;  // Clear buffer
	localparam int unsigned TBB_F_RDCNT  = 6;  // Read word counter
	localparam int unsigned TBB_F_WRTAPE = 7;  // Write tape
	localparam int unsigned TBB_F_RDTAPE = 8;  // Read tape
	localparam int unsigned TBB_F_BACK   = 9;  // Read backward
	localparam int unsigned TBB_F_VAR    = 10; // Variable format
	localparam int unsigned TBB_F_STOP   = 11; // Stop after one block
	localparam int unsigned TBB_F_DENS   = 12; // Density
	localparam int unsigned TBB_F_SPACE  = 13; // Spacing, 2 bits
	localparam int unsigned TBB_F_UNIT   = 16; // Tape unit number, 4 bits

	// ==========================================================
	// Test-jump selectors
	localparam logic [2:0] TBB_J_ACT1 = 3'h4;
	localparam logic [2:0] TBB_J_ACT2 = 3'h5;
	localparam logic [2:0] TBB_J_ERR1 = 3'h6;
	localparam logic [2:0] TBB_J_ERR2 = 3'h7;

	// ==========================================================
	// Buffer sequencer states
	typedef enum logic [2:0] {
		TBB_IDLE   = 3'b000,
		TBB_FILL   = 3'b001,
		TBB_DRAIN  = 3'b010,
		TBB_TOTAPE = 3'b011,
		TBB_FRTAPE = 3'b100
	} tbb_state_t;

endpackage

// ===== verilog/tbb_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module tbb_fifo #(
	parameter int unsigned WIDTH = 36,
	parameter int unsigned DEPTH = 4
) (
	// Clock, reset, enable and flush
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             ce,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	// ==========================================================
	// Storage and pointers
	logic [WIDTH-1:0] mem_reg [DEPTH];   // Entries
	logic [AW-1:0]    wr_ptr_reg;        // Next write slot
	logic [AW-1:0]    rd_ptr_reg;        // Oldest entry
	logic [AW:0]      level_reg;         // Occupancy
	logic             push;
	logic             pop;

	assign in_ready  = (level_reg != DEPTH[AW:0]);
	assign out_valid = (level_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Entry write; data needs no reset
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointer and level bookkeeping
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else if (ce) begin
			if (flush) begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
				level_reg  <= '0;
			end else begin
				if (push) begin
					wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					              : wr_ptr_reg + 1'b1;
				end
				if (pop) begin
					rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					              : rd_ptr_reg + 1'b1;
				end
				if (push && !pop) begin
					level_reg <= level_reg + 1'b1;
				end else if (pop && !push) begin
					level_reg <= level_reg - 1'b1;
				end
			end
		end
	end
endmodule

// ===== verilog/tbb_buffer_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// R01: Software ends short loads with end-transfer
// R02: Redundant end-transfer after full load is harmless
// R03: Active while tape transfer or unit moving
// R04: Inactive only when idle, settled, not moving
// R05: Activity test branches when active, selectors 4/5
// R06: Write-buffer prepares load from I/O register
// R07: Fixed block: computer sends exactly 120 words
// R08: Tape write carries unit, density, spacing, stop
// R09: Tape write starts only in unload state
// R10: End-transfer switches buffer to unload
// R11: Variable format allows up to 120 words
// R12: Tape read routes blocks to paired buffer
// R13: Tape read starts only in load state
// R14: Error test falls through on error, 6/7
// R15: Read errors stop tape, flag, no fault
// R16: Fixed error count: 120 parity, 0 end-record; counter keeps the words received instead
// R17: Extra lines advance counter, saturating at 127
// R18: Read-buffer streams words through I/O register
// R19: Pending word held until computer reads it
// R20: New function selection discards pending word
// R21: Clear resets counter, memory, sets load state
// R22: Read errors never reach I/O status register
// R23: Master clear empties buffers, load state
// R24: Counter up per word in, down per out
// R25: All memory traffic passes transfer register
// R26: Read-word-count places count in I/O register
// R27: Command bits decoded from function operand
module tbb_buffer_ctrl
	import tbb_pkg::*;
#(
	parameter logic BUF_ID = 1'b0  // 0: buffer one, 1: buffer two
) (
	// Clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    ce,
	// External function from the computer
	input  wire logic                    external_function_cmd,
	input  wire logic [TBB_WORD_W-1:0]   function_operand,
	// Computer word strobes through the I/O buffer register
	input  wire logic                    external_write_word,
	input  wire logic [TBB_WORD_W-1:0]   write_data,
	input  wire logic                    external_read_word,
	output logic [TBB_WORD_W-1:0]        io_buffer_register,
	output logic                         io_word_pending,
	// Conditional test jump
	input  wire logic                    conditional_test_jump,
	input  wire logic [2:0]              jump_selector,
	output logic                         jump_taken,
	// Tape control unit side
	output logic                         tape_write_start,
	output logic                         tape_read_start,
	output logic [19:0]                  tape_command,
	output logic                         tape_stop,
	input  wire logic                    tape_unit_moving,
	output logic [TBB_WORD_W-1:0]        tape_shift_register,
	output logic                         tape_word_valid,
	input  wire logic                    tape_word_ready,
	input  wire logic                    tape_word_in_valid,
	input  wire logic [TBB_WORD_W-1:0]   tape_word_in,
	output logic                         tape_word_in_ready,
	input  wire logic                    tape_extra_line,
	input  wire logic                    tape_end_of_block,
	input  wire logic                    tape_parity_error,
	input  wire logic                    tape_sprocket_error,
	input  wire logic                    tape_end_of_record,
	// Status
	output logic                         buffer_active,
	output logic                         buffer_unload,
	output logic                         read_error,
	output logic [TBB_CNT_W-1:0]         buffer_word_counter,
	output logic                         io_status_error
);
	import tbb_pkg::*;

	// ==========================================================
	// Command decode
	logic own_sel;     // Operand addresses this buffer
	logic cmd_wrbuf;
	logic cmd_rdbuf;
	logic cmd_endx;
	logic cmd_clr;
	logic cmd_rdcnt;
	logic cmd_wrtape;
	logic cmd_rdtape;

	assign own_sel = function_operand[BUF_ID ? TBB_F_BUF2 : TBB_F_BUF1];
	// Select bits take effect only with this buffer's number // R27
	assign cmd_wrbuf  = external_function_cmd && own_sel
	                    && function_operand[TBB_F_WRBUF];
	assign cmd_rdbuf  = external_function_cmd && own_sel
	                    && function_operand[TBB_F_RDBUF];
	assign cmd_endx   = external_function_cmd && own_sel
	                    && function_operand[TBB_F_ENDX];
	assign cmd_clr    = external_function_cmd && own_sel
	                    && function_operand[TBB_F_CLR];
	assign cmd_rdcnt  = external_function_cmd && own_sel
	                    && function_operand[TBB_F_RDCNT];
	assign cmd_wrtape = external_function_cmd && own_sel
	                    && function_operand[TBB_F_WRTAPE];
	assign cmd_rdtape = external_function_cmd && own_sel
	                    && function_operand[TBB_F_RDTAPE];

	// ==========================================================
	// State
	tbb_state_t                  state_reg;       // Sequencer
	logic                        unload_reg;      // Load/unload switch
	logic [TBB_CNT_W-1:0]        count_reg;       // Word counter
	logic [TBB_ADDR_W-1:0]       ptr_reg;         // Drain pointer
	logic [TBB_WORD_W-1:0]       mem_reg [TBB_DEPTH]; // Block memory
	logic [TBB_WORD_W-1:0]       xfer_reg;        // Transfer register
	logic                        xfer_full_reg;   // Transfer reg holds word
	logic                        error_reg;       // Read error flag
	logic                        stop_reg;        // Stop after block
	logic                        var_reg;         // Variable format
	logic                        clear_mem;       // Wipe memory
	logic                        at_full;
	logic                        at_zero;

	assign at_full   = (count_reg == TBB_CNT_FULL);
	assign at_zero   = (count_reg == TBB_CNT_ZERO);
	assign clear_mem = cmd_clr;

	// ==========================================================
	// Inbound FIFO: computer words queue before the transfer register
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [TBB_WORD_W-1:0] fifo_out_data;

	// Accept computer words only while filling
	assign fifo_in_valid  = external_write_word
	                        && (state_reg == TBB_FILL); // R06
	// Refill as the held word is stored: keeps up with back-to-back writes
	assign fifo_out_ready = (state_reg == TBB_FILL) && !at_full;

	tbb_fifo #(
		.WIDTH (TBB_WORD_W),
		.DEPTH (TBB_FIFO_D)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.flush     (cmd_clr || cmd_endx),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (write_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ==========================================================
	// Word movement events
	logic word_in;    // Transfer register into memory
	logic word_out;   // Memory into transfer register
	logic tape_in;
	logic to_io;
	logic to_tape;

	assign tape_in  = tape_word_in_valid && (state_reg == TBB_FRTAPE)
	                  && tape_word_in_ready;
	assign word_in  = xfer_full_reg
	                  && ((state_reg == TBB_FILL)
	                      || (state_reg == TBB_FRTAPE));
	assign word_out = !xfer_full_reg && !at_zero
	                  && ((state_reg == TBB_DRAIN)
	                      || (state_reg == TBB_TOTAPE));
	// Pending I/O word taken by a read strobe // R19
	assign to_io    = (state_reg == TBB_DRAIN) && xfer_full_reg
	                  && (!io_word_pending || external_read_word);
	assign to_tape  = (state_reg == TBB_TOTAPE) && xfer_full_reg
	                  && (!tape_word_valid || tape_word_ready);

	// Transfer register: every word passes through it // R25
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xfer_reg      <= '0;
			xfer_full_reg <= 1'b0;
		end else if (ce) begin
			if (cmd_clr || cmd_endx) begin
				xfer_full_reg <= 1'b0;
			end else if (fifo_out_valid && fifo_out_ready) begin
				xfer_reg      <= fifo_out_data;
				xfer_full_reg <= 1'b1;
			end else if (tape_in) begin
				xfer_reg      <= tape_word_in;
				xfer_full_reg <= 1'b1;
			end else if (word_out) begin
				xfer_reg      <= mem_reg[ptr_reg];
				xfer_full_reg <= 1'b1;
			end else if (word_in || to_io || to_tape) begin
				xfer_full_reg <= 1'b0;
			end
		end
	end

	// Block memory, one entry per index
	genvar gi;
	generate
		for (gi = 0; gi < TBB_DEPTH; gi++) begin : g_mem
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					mem_reg[gi] <= '0; // R23
				end else if (ce) begin
					if (clear_mem) begin
						mem_reg[gi] <= '0; // R21
					end else if (word_in && !at_full
					             && count_reg == TBB_CNT_W'(gi)) begin
						mem_reg[gi] <= xfer_reg;
					end
				end
			end
		end
	endgenerate

	// Word counter: up on entry, down on exit, saturate on extra lines
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= TBB_CNT_ZERO; // R23
			ptr_reg   <= '0;
		end else if (ce) begin
			if (cmd_clr) begin
				count_reg <= TBB_CNT_ZERO; // R21
				ptr_reg   <= '0;
			end else if (word_in && !at_full) begin
				count_reg <= count_reg + 1'b1; // R24
			end else if (word_out) begin
				count_reg <= count_reg - 1'b1; // R24
				ptr_reg   <= ptr_reg + 1'b1;
			end else if (state_reg == TBB_FRTAPE && tape_extra_line
			             && count_reg != TBB_CNT_MAX) begin
				count_reg <= count_reg + 1'b1; // R17
			end else if (state_reg == TBB_IDLE) begin
				ptr_reg <= '0;
			end
		end
	end

	// ==========================================================
	// Sequencer and load/unload switch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= TBB_IDLE;
			unload_reg <= 1'b0; // R23
			stop_reg   <= 1'b0;
			var_reg    <= 1'b0;
		end else if (ce) begin
			if (cmd_clr) begin
				state_reg  <= TBB_IDLE;
				unload_reg <= 1'b0; // R21
			end else if (cmd_endx) begin
				// Harmless when already unloaded and idle // R02
				state_reg  <= TBB_IDLE;
				unload_reg <= 1'b1; // R10
			end else begin
				case (state_reg)
				TBB_IDLE: begin
					if (cmd_wrbuf && !unload_reg) begin
						state_reg <= TBB_FILL; // R06
					end else if (cmd_rdbuf && unload_reg) begin
						state_reg <= TBB_DRAIN; // R18
					end else if (cmd_wrtape && unload_reg) begin
						state_reg <= TBB_TOTAPE; // R09
						stop_reg  <= function_operand[TBB_F_STOP];
						var_reg   <= function_operand[TBB_F_VAR]; // R11
					end else if (cmd_rdtape && !unload_reg) begin
						state_reg <= TBB_FRTAPE; // R13
						stop_reg  <= function_operand[TBB_F_STOP];
						var_reg   <= function_operand[TBB_F_VAR];
					end
				end
				TBB_FILL: begin
					// Fixed format flips at a full block
					if (at_full && !var_reg) begin
						state_reg  <= TBB_IDLE;
						unload_reg <= 1'b1;
					end
				end
				TBB_DRAIN, TBB_TOTAPE: begin
					if (at_zero && !xfer_full_reg) begin
						state_reg  <= TBB_IDLE;
						unload_reg <= 1'b0;
					end
				end
				TBB_FRTAPE: begin
					// Block end or error closes the read // R15
					if (tape_end_of_block || tape_parity_error
					    || tape_sprocket_error || tape_end_of_record) begin
						state_reg  <= TBB_IDLE;
						unload_reg <= 1'b1;
					end
				end
				default: state_reg <= TBB_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Read error flag; cleared by a new read or a clear, event wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			error_reg <= 1'b0;
		end else if (ce) begin
			if (state_reg == TBB_FRTAPE && (tape_parity_error
			    || tape_sprocket_error || tape_end_of_record)) begin
				error_reg <= 1'b1; // R15
			end else if (cmd_rdtape || cmd_clr) begin
				error_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// I/O buffer register: drained words and the word count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			io_buffer_register <= '0;
			io_word_pending    <= 1'b0;
		end else if (ce) begin
			if (cmd_rdcnt) begin
				io_buffer_register <= {29'h0, count_reg}; // R26
				io_word_pending    <= 1'b1;
			end else if (external_function_cmd) begin
				// Any other selection drops the held word // R20
				io_word_pending <= 1'b0;
			end else if (to_io) begin
				io_buffer_register <= xfer_reg; // R18
				io_word_pending    <= 1'b1;
			end else if (external_read_word) begin
				io_word_pending <= 1'b0; // R19
			end
		end
	end

	// ==========================================================
	// Tape side outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tape_write_start    <= 1'b0;
			tape_read_start     <= 1'b0;
			tape_command        <= '0;
			tape_stop           <= 1'b0;
			tape_shift_register <= '0;
			tape_word_valid     <= 1'b0;
			tape_word_in_ready  <= 1'b0;
		end else if (ce) begin
			tape_write_start <= cmd_wrtape && unload_reg
			                    && state_reg == TBB_IDLE; // R09
			tape_read_start  <= cmd_rdtape && !unload_reg
			                    && state_reg == TBB_IDLE; // R12
			if ((cmd_wrtape || cmd_rdtape) && state_reg == TBB_IDLE) begin
				tape_command <= function_operand[19:0]; // R08
			end
			// Errors halt the unit in the next gap // R15
			tape_stop <= (state_reg == TBB_FRTAPE) && (tape_parity_error
			             || tape_sprocket_error || tape_end_of_record
			             || (tape_end_of_block && stop_reg));
			if (to_tape) begin
				tape_shift_register <= xfer_reg;
				tape_word_valid     <= 1'b1;
			end else if (tape_word_ready) begin
				tape_word_valid <= 1'b0;
			end
			tape_word_in_ready <= (state_reg == TBB_FRTAPE)
			                      && !xfer_full_reg && !tape_in;
		end
	end

	// ==========================================================
	// Status and jump answers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buffer_active       <= 1'b0;
			buffer_unload       <= 1'b0;
			read_error          <= 1'b0;
			buffer_word_counter <= '0;
			jump_taken          <= 1'b0;
			io_status_error     <= 1'b0;
		end else if (ce) begin
			// R03 R04
			buffer_active <= (state_reg == TBB_TOTAPE)
			                 || (state_reg == TBB_FRTAPE) || tape_unit_moving;
			buffer_unload       <= unload_reg;
			read_error          <= error_reg;
			buffer_word_counter <= count_reg;
			io_status_error     <= 1'b0; // R22
			if (conditional_test_jump) begin
				case (jump_selector)
				TBB_J_ACT1: jump_taken <= !BUF_ID && buffer_active; // R05
				TBB_J_ACT2: jump_taken <= BUF_ID && buffer_active;  // R05
				TBB_J_ERR1: jump_taken <= !BUF_ID && !error_reg;    // R14
				TBB_J_ERR2: jump_taken <= BUF_ID && !error_reg;     // R14
				default:    jump_taken <= 1'b0;
				endcase
			end else begin
				jump_taken <= 1'b0;
			end
		end
	end
	// Counter keeps the words received on an error; no error count is loaded // R16
endmodule

// ===== verif/tbb_tape_model.sv
`timescale 1ns/1ps
// Behavioural tape control unit facing one buffer
module tbb_tape_model (
	// Clock and reset
	input	wire logic		clk,
	input	wire logic		arst_n,
	// Requests from the buffer
	input	wire logic		tape_write_start,
	input	wire logic		tape_read_start,
	input	wire logic		tape_stop,
	input	wire logic		tape_word_valid,
	input	wire logic		tape_word_in_ready,
	// Scenario knobs
	input	wire logic [6:0]	blk_len,
	input	wire logic [1:0]	err_kind,
	// Answers to the buffer
	output	logic			tape_word_ready,
	output	logic			tape_word_in_valid,
	output	logic [35:0]		tape_word_in,
	output	logic			tape_unit_moving,
	output	logic			tape_end_of_block,
	output	logic			tape_parity_error,
	output	logic			tape_sprocket_error,
	output	logic			tape_end_of_record
);
	logic		rd_reg;		// Block being read
	logic [6:0]	sent_reg;	// Words handed over
	logic [4:0]	idle_reg;	// Quiet cycles while writing
	// Released line shows the inverse, never a stale word
	assign tape_word_in = tape_word_in_valid ? 36'h5a5a00000 + sent_reg
		: ~(36'h5a5a00000 + sent_reg);
	assign tape_parity_error = tape_end_of_block && err_kind == 2'h1;
	assign tape_sprocket_error = tape_end_of_block && err_kind == 2'h2;
	assign tape_end_of_record = tape_end_of_block && err_kind == 2'h3;
	// ==========================================================
	// Motion and word exchange; ready only every other cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{rd_reg, tape_word_ready, tape_word_in_valid} <= 3'h0;
			{tape_unit_moving, tape_end_of_block} <= 2'h0;
			sent_reg <= 7'h00;
			idle_reg <= 5'h00;
		end else begin
			tape_end_of_block <= 1'b0;
			tape_word_ready <= ~tape_word_ready;
			if (tape_word_valid || tape_write_start)
				idle_reg <= 5'h00;
			else if (tape_unit_moving && !rd_reg)
				idle_reg <= idle_reg + 5'h01;
			if (tape_stop || &idle_reg)
				tape_unit_moving <= 1'b0;
			if (tape_write_start || tape_read_start)
				tape_unit_moving <= 1'b1;
			if (tape_read_start) begin
				rd_reg <= 1'b1;
				sent_reg <= 7'h00;
			end else if (rd_reg) begin
				if (tape_word_in_valid && tape_word_in_ready) begin
					tape_word_in_valid <= 1'b0;
					sent_reg <= sent_reg + 7'h01;
				end else if (!tape_word_in_valid && sent_reg < blk_len)
					tape_word_in_valid <= 1'b1;
				else if (!tape_word_in_valid) begin
					tape_end_of_block <= 1'b1;
					rd_reg <= 1'b0;
					tape_unit_moving <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== verif/tbb_buffer_ctrl_properties.sv
`timescale 1ns/1ps
// Port-level checks for one buffer controller
module tbb_buffer_ctrl_props
	import tbb_pkg::*;
#(
	parameter logic BUF_ID = 1'b0
) (
	input	wire logic			clk,
	input	wire logic			arst_n,
	input	wire logic			external_function_cmd,
	input	wire logic [TBB_WORD_W-1:0]	function_operand,
	input	wire logic			conditional_test_jump,
	input	wire logic [2:0]		jump_selector,
	input	wire logic			jump_taken,
	input	wire logic			tape_write_start,
	input	wire logic			tape_read_start,
	input	wire logic [19:0]		tape_command,
	input	wire logic			buffer_active,
	input	wire logic			buffer_unload,
	input	wire logic			read_error,
	input	wire logic [TBB_CNT_W-1:0]	buffer_word_counter,
	input	wire logic			io_status_error
);
	logic	sel;	// Command addressed to this buffer
	assign sel = function_operand[BUF_ID ? TBB_F_BUF2 : TBB_F_BUF1];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Assertions
	io_status_quiet_a: assert property (io_status_error == 1'b0)
		else $error("status error raised");
	act_jump_a: assert property (conditional_test_jump &&
		jump_selector == (BUF_ID ? TBB_J_ACT2 : TBB_J_ACT1)
		|=> jump_taken == $past(buffer_active)) else $error("act jump");
	err_jump_a: assert property (conditional_test_jump &&
		jump_selector == (BUF_ID ? TBB_J_ERR2 : TBB_J_ERR1)
		|=> jump_taken == !$past(read_error)) else $error("err jump");
	write_unload_a: assert property (tape_write_start
		|-> $past(buffer_unload)) else $error("write not unloaded");
	read_load_a: assert property (tape_read_start
		|-> !$past(buffer_unload)) else $error("read not loaded");
	write_active_a: assert property (tape_write_start
		|-> ##[0:2] buffer_active) else $error("write not active");
	start_pulse_a: assert property (tape_read_start
		|=> !tape_read_start) else $error("start held");
	cmd_copy_a: assert property (tape_write_start || tape_read_start
		|-> tape_command == $past(function_operand[19:0]))
		else $error("tape command");
	clear_buf_a: assert property (external_function_cmd && sel &&
		function_operand[TBB_F_CLR] && !buffer_active |=> ##[0:2]
		(buffer_word_counter == TBB_CNT_ZERO && !buffer_unload))
		else $error("clear failed");
	end_xfer_a: assert property (external_function_cmd && sel &&
		function_operand[TBB_F_ENDX] && !buffer_active &&
		buffer_word_counter != TBB_CNT_ZERO |=> ##[0:2] buffer_unload)
		else $error("end transfer");
	cover property (tape_write_start);
	cover property (tape_read_start);
	cover property (read_error && !buffer_active);
endmodule
bind tbb_buffer_ctrl tbb_buffer_ctrl_props #(.BUF_ID(BUF_ID)) props_i (.*);

// ===== verif/tbb_buffer_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tbb_buffer_ctrl_test;
	import tbb_pkg::*;
	localparam logic [35:0] WBASE = 36'h5a5a00000;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, tape_extra_line = 1'b0;
	logic external_function_cmd = 1'b0, external_write_word = 1'b0;
	logic external_read_word = 1'b0, conditional_test_jump = 1'b0;
	logic [2:0] jump_selector = 3'h0;
	logic [35:0] function_operand = '0, write_data = '0;
	logic [35:0] io_buffer_register, tape_shift_register, tape_word_in;
	logic [19:0] tape_command;
	logic [6:0] buffer_word_counter, blk_len = 7'h00;
	logic [1:0] err_kind = 2'h0;
	logic io_word_pending, jump_taken, tape_write_start, tape_read_start;
	logic tape_stop, tape_unit_moving, tape_word_valid, tape_word_ready;
	logic tape_word_in_valid, tape_word_in_ready, tape_end_of_block;
	logic tape_parity_error, tape_sprocket_error, tape_end_of_record;
	logic buffer_active, buffer_unload, read_error, io_status_error;
	int failures = 0, n_tests = 0;
	always #50 clk = ~clk;
	tbb_buffer_ctrl #(.BUF_ID(1'b0)) tbb_buffer_ctrl_i (.*);
	tbb_tape_model tbb_tape_model_i (.*);
	// ==========================================================
	// Bus helpers; inputs move 1 ns after the rising edge
	task automatic tick(); @(posedge clk); #1; endtask
	task automatic fn(input logic [19:0] b);
		external_function_cmd = 1'b1;
		function_operand = {16'h0, b} | 36'h1;
		tick();
		external_function_cmd = 1'b0;
		tick();
	endtask
	task automatic jump(input logic [2:0] s, input logic e);
		conditional_test_jump = 1'b1;
		jump_selector = s;
		tick();
		conditional_test_jump = 1'b0;
		`CHK(jump_taken, e)
		tick();
	endtask
	task automatic take(input logic [35:0] e, input logic [35:0] m);
		for (int i = 0; i < 50 && io_word_pending !== 1'b1; i++) tick();
		if (io_word_pending !== 1'b1) begin failures++; print_verdict(); end
		`CHK(io_buffer_register & m, e)
		external_read_word = 1'b1;
		tick();
		external_read_word = 1'b0;
		tick();
	endtask
	task automatic wait_idle();
		int i;
		tick();
		for (i = 0; i < 3000 && buffer_active !== 1'b0; i++) tick();
		if (i == 3000) begin failures++; print_verdict(); end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic write_block(input int n, input logic vf);
		fn(20'h1 << TBB_F_WRBUF);
		external_write_word = 1'b1;
		for (int i = 0; i < n; i++) begin
			write_data = 36'h0c0de0000 + 36'(i);
			tick();
		end
		external_write_word = 1'b0;
		repeat (6) tick();
		`CHK(buffer_word_counter, 7'(n))
		`CHK(buffer_unload, 1'(n == 120))
		fn(20'h1 << TBB_F_ENDX);
		`CHK(buffer_unload, 1'b1)
		fn(20'h1 << TBB_F_RDTAPE);
		`CHK(buffer_active, 1'b0)
		fn(20'h30000 | 20'h1 << TBB_F_WRTAPE | 20'(vf) << TBB_F_VAR);
		`CHK(buffer_active, 1'b1)
		jump(TBB_J_ACT1, 1'b1);
		wait_idle();
		`CHK(buffer_word_counter, TBB_CNT_ZERO)
		`CHK(buffer_unload, 1'b0)
	endtask
	task automatic read_block(input logic [6:0] n, input logic [1:0] ek);
		blk_len = n;
		err_kind = ek;
		fn(20'h50000 | 20'h1 << TBB_F_RDTAPE);
		`CHK(buffer_active, 1'b1)
		wait_idle();
		jump(TBB_J_ACT1, 1'b0);
		jump(TBB_J_ERR1, 1'(ek == 2'h0));
		`CHK(io_status_error, 1'b0)
		fn(20'h1 << TBB_F_RDCNT);
		take({29'h0, n}, 36'h7f);
		if (n > 7'h2) begin
			fn(20'h1 << TBB_F_RDBUF);
			take(WBASE, '1);
			repeat (8) tick();
			`CHK(io_word_pending, 1'b1)
			take(WBASE + 36'h1, '1);
		end
		fn(20'h1 << TBB_F_CLR);
		`CHK(io_word_pending, 1'b0)
		`CHK(buffer_word_counter, TBB_CNT_ZERO)
		`CHK(buffer_unload, 1'b0)
	endtask
	initial begin
		repeat (16) tick();
		arst_n = 1'b1;
		`CHK(buffer_word_counter, TBB_CNT_ZERO)
		`CHK(buffer_unload, 1'b0)
		write_block(120, 1'b0);
		write_block(3, 1'b1);
		read_block(7'h05, 2'h0);
		read_block(7'h07, 2'h1);
		read_block(7'h04, 2'h2);
		read_block(7'h00, 2'h3);
		print_verdict();
	end
endmodule
